// ===== ppa_port.sv
// register side of the parallel master port: address, pad enables, buffer status
// assumes an apb master on pclk and an external peripheral on pads and buffer strobes
//
// Operation
// - two port transfers always have at least one idle cycle between them.
// - destination bit 15 drives the second chip select active when one.
// - destination bit 14 drives the first chip select active when one.
// - destination bits 13 to 0 are the address shown on the port address lines.
// - pin enable bits 15 and 14 give pads 15 and 14 to the chip selects, else gpio.
// - pin enable bits 13 to 2 give pads 13 to 2 to the address lines, else gpio.
// - pin enable bits 1 and 0 give pads 1 and 0 to address bits 1 and 0, else gpio.
// - an input full flag is set while its buffer holds unread data and clears on read.
// - an output empty flag is set while its buffer is empty and clears on write.
// - reading an empty output byte sets the underflow flag until software clears it.
// - the summary empty flag reads one only when every output buffer is empty.
`timescale 1ns/1ns
module ppa_port #(
  parameter int NBUF = 4
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  output logic               irq,
  input  wire logic [15:0]   gpio_out,
  input  wire logic [15:0]   gpio_oe,
  output logic      [15:0]   pad_out,
  output logic      [15:0]   pad_oe,
  input  wire logic [7:0]    port_data_in,
  output logic      [7:0]    port_data_out,
  output logic               port_data_oe,
  output logic               port_rd_strobe,
  output logic               port_wr_strobe,
  input  wire logic [NBUF-1:0] ext_in_fill,
  input  wire logic [7:0]    ext_in_data,
  input  wire logic [NBUF-1:0] ext_out_drain,
  output logic      [7:0]    ext_out_data
);

  // ***************************************************
  // apb decode
  // ***************************************************
  logic [31:0] rdata_nxt;
  logic        hit;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;

  // one wait state: the answer is taken at the edge after pready_r rises
  wire logic access_go  = psel & penable & ~pready_r;
  wire logic access_end = psel & penable & pready_r;
  wire logic wr_end     = access_end & pwrite & ~pslverr_r;
  wire logic rd_end     = access_end & ~pwrite & ~pslverr_r;

  wire logic sel_dest   = (paddr == ppa_pkg::OFF_DEST_ADDR);
  wire logic sel_pin    = (paddr == ppa_pkg::OFF_PIN_EN);
  wire logic sel_stat   = (paddr == ppa_pkg::OFF_BUF_STAT);
  wire logic sel_istat  = (paddr == ppa_pkg::OFF_IRQ_STAT);
  wire logic sel_imask  = (paddr == ppa_pkg::OFF_IRQ_MASK);
  wire logic sel_ctrl   = (paddr == ppa_pkg::OFF_XFER_CTRL);
  wire logic sel_data   = (paddr == ppa_pkg::OFF_XFER_DATA);

  // buffer windows: four words starting at each base
  function automatic logic in_window(input logic [7:0] a, input logic [7:0] base);
    in_window = (a[7:4] == base[7:4]) && (a[1:0] == 2'b00) && (a[3:2] < NBUF[1:0] || NBUF > 3);
  endfunction

  wire logic       sel_inb  = in_window(paddr, ppa_pkg::OFF_IN_BUF0);
  wire logic       sel_outb = in_window(paddr, ppa_pkg::OFF_OUT_BUF0);
  wire logic [1:0] buf_idx  = paddr[3:2];

  assign hit = sel_dest | sel_pin | sel_stat | sel_istat | sel_imask | sel_ctrl | sel_data | sel_inb | sel_outb;

  // ***************************************************
  // programmed registers
  // ***************************************************
  logic [15:0]             dest_r;
  logic [15:0]             pin_en_r;
  logic [ppa_pkg::IRQ_W-1:0] irq_stat_r;
  logic [ppa_pkg::IRQ_W-1:0] irq_mask_r;
  logic [7:0]              xfer_wdata_r;
  logic [7:0]              xfer_rdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dest_r       <= ppa_pkg::DEST_ADDR_RST;
      pin_en_r     <= ppa_pkg::PIN_EN_RST;
      irq_mask_r   <= ppa_pkg::IRQ_RST;
      xfer_wdata_r <= ppa_pkg::BYTE_RST;
    end else if (wr_end) begin
      if (sel_dest)
        dest_r <= pwdata[15:0];
      if (sel_pin)
        pin_en_r <= pwdata[15:0];
      if (sel_imask)
        irq_mask_r <= pwdata[ppa_pkg::IRQ_W-1:0];
      if (sel_data)
        xfer_wdata_r <= pwdata[7:0];
    end
  end

  // ***************************************************
  // buffers
  // ***************************************************
  logic [NBUF-1:0] in_full;
  logic [NBUF-1:0] out_full;
  logic [7:0]      in_rd_data;
  logic [7:0]      out_rd_data;
  logic            in_over;
  logic            out_under;
  logic [1:0]      out_idx;

  wire logic [NBUF-1:0] in_drain = (rd_end & sel_inb) ? NBUF'(1) << buf_idx : '0;
  wire logic [NBUF-1:0] out_fill = (wr_end & sel_outb) ? NBUF'(1) << buf_idx : '0;

  ppa_buf_bank #(.NUM(NBUF), .IDX(2)) u_in_bank (
    .pclk      (pclk),
    .presetn   (presetn),
    .fill      (ext_in_fill),
    .fill_data (ext_in_data),
    .drain     (in_drain),
    .rd_idx    (buf_idx),
    .rd_data   (in_rd_data),
    .full_r    (in_full),
    .over_evt  (in_over),
    .under_evt ()
  );

  // lowest drain strobe picks the byte handed out
  always_comb begin
    out_idx = 2'b00;
    for (int i = NBUF - 1; i >= 0; i--) begin
      if (ext_out_drain[i])
        out_idx = 2'(i);
    end
  end

  ppa_buf_bank #(.NUM(NBUF), .IDX(2)) u_out_bank (
    .pclk      (pclk),
    .presetn   (presetn),
    .fill      (out_fill),
    .fill_data (pwdata[7:0]),
    .drain     (ext_out_drain),
    .rd_idx    (out_idx),
    .rd_data   (out_rd_data),
    .full_r    (out_full),
    .over_evt  (),
    .under_evt (out_under)
  );

  // ***************************************************
  // status flags
  // ***************************************************
  logic in_ovf_r;
  logic out_unf_r;
  logic full_d_r;
  logic empty_d_r;

  wire logic [NBUF-1:0] out_empty = ~out_full;
  wire logic            all_full  = &in_full;
  wire logic            all_empty = &out_empty;
  wire logic            stat_wr   = wr_end & sel_stat;

  // set wins over a software clear landing in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_ovf_r  <= 1'b0;
      out_unf_r <= 1'b0;
    end else begin
      if (in_over)
        in_ovf_r <= 1'b1;
      else if (stat_wr && !pwdata[ppa_pkg::IN_OVF_BIT])
        in_ovf_r <= 1'b0;
      if (out_under)
        out_unf_r <= 1'b1;
      else if (stat_wr && !pwdata[ppa_pkg::OUT_UNF_BIT])
        out_unf_r <= 1'b0;
    end
  end

  // other status bits are hardware state only; writes never reach them
  wire logic [15:0] stat_word = {all_full, in_ovf_r, 2'b00, in_full, all_empty, out_unf_r, 2'b00, out_empty};

  // ***************************************************
  // transfer sequencer
  // ***************************************************
  ppa_pkg::ppa_xfer_e st_r;
  ppa_pkg::ppa_xfer_e st_nxt;
  logic               pend_wr_r;
  logic               pend_rd_r;
  logic               rd_strobe_r;
  logic               wr_strobe_r;

  wire logic ctrl_wr  = wr_end & sel_ctrl;
  wire logic req_wr   = ctrl_wr & pwdata[ppa_pkg::CTRL_WR_BIT];
  wire logic req_rd   = ctrl_wr & pwdata[ppa_pkg::CTRL_RD_BIT];
  wire logic pend     = pend_wr_r | pend_rd_r;
  wire logic launch   = (st_r == ppa_pkg::ST_IDLE) && pend;
  wire logic busy     = (st_r != ppa_pkg::ST_IDLE) | pend;
  wire logic done_evt = (st_r == ppa_pkg::ST_STROBE);

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ppa_pkg::ST_IDLE:   if (pend) st_nxt = ppa_pkg::ST_STROBE;
      ppa_pkg::ST_STROBE: st_nxt = ppa_pkg::ST_GAP;
      ppa_pkg::ST_GAP:    st_nxt = ppa_pkg::ST_IDLE;
    endcase
  end

  // a request is held until the sequencer is idle again; read has priority
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= ppa_pkg::ST_IDLE;
      pend_wr_r <= 1'b0;
      pend_rd_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (launch) begin
        pend_rd_r <= req_rd;
        pend_wr_r <= pend_rd_r ? (pend_wr_r | req_wr) : req_wr;
      end else begin
        pend_rd_r <= pend_rd_r | req_rd;
        pend_wr_r <= pend_wr_r | req_wr;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_strobe_r  <= 1'b0;
      wr_strobe_r  <= 1'b0;
      xfer_rdata_r <= ppa_pkg::BYTE_RST;
    end else begin
      rd_strobe_r <= launch & pend_rd_r;
      wr_strobe_r <= launch & ~pend_rd_r;
      if (rd_strobe_r)
        xfer_rdata_r <= port_data_in;
    end
  end

  // ***************************************************
  // pads
  // ***************************************************
  wire logic [15:0] func_out = {dest_r[ppa_pkg::CS_TWO_BIT],
                                dest_r[ppa_pkg::CS_ONE_BIT],
                                dest_r[ppa_pkg::ADDR_MSB:0]};

  ppa_pad_mux #(.PADS(16)) u_pads (
    .pclk      (pclk),
    .presetn   (presetn),
    .func_en   (pin_en_r),
    .func_out  (func_out),
    .gpio_out  (gpio_out),
    .gpio_oe   (gpio_oe),
    .pad_out_r (pad_out),
    .pad_oe_r  (pad_oe)
  );

  // ***************************************************
  // interrupts and read data
  // ***************************************************
  logic [ppa_pkg::IRQ_W-1:0] irq_evt;
  logic                      irq_r;
  logic                      data_oe_r;
  logic [7:0]                ext_out_r;

  // summary flags raise an event only on their rising edge
  assign irq_evt = {all_empty & ~empty_d_r, all_full & ~full_d_r, out_under, in_over, done_evt};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= ppa_pkg::IRQ_RST;
      full_d_r   <= 1'b0;
      empty_d_r  <= 1'b1;
      irq_r      <= 1'b0;
      data_oe_r  <= 1'b0;
      ext_out_r  <= ppa_pkg::BYTE_RST;
    end else begin
      irq_stat_r <= irq_evt | (irq_stat_r & ~((wr_end & sel_istat) ? pwdata[ppa_pkg::IRQ_W-1:0] : '0));
      full_d_r   <= all_full;
      empty_d_r  <= all_empty;
      irq_r      <= |(irq_stat_r & irq_mask_r);
      data_oe_r  <= launch & ~pend_rd_r;
      if (|ext_out_drain)
        ext_out_r <= out_rd_data;
    end
  end

  always_comb begin
    rdata_nxt = '0;
    if (sel_dest)
      rdata_nxt[15:0] = dest_r;
    if (sel_pin)
      rdata_nxt[15:0] = pin_en_r;
    if (sel_stat)
      rdata_nxt[15:0] = stat_word;
    if (sel_istat)
      rdata_nxt[ppa_pkg::IRQ_W-1:0] = irq_stat_r;
    if (sel_imask)
      rdata_nxt[ppa_pkg::IRQ_W-1:0] = irq_mask_r;
    if (sel_ctrl)
      rdata_nxt[ppa_pkg::CTRL_BUSY_BIT] = busy;
    if (sel_data)
      rdata_nxt[15:0] = {xfer_rdata_r, xfer_wdata_r};
    if (sel_inb)
      rdata_nxt[7:0] = in_rd_data;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r <= access_go;
      if (access_go) begin
        pslverr_r <= ~hit;
        prdata_r  <= hit ? rdata_nxt : '0;
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign irq            = irq_r;
  assign port_data_out  = xfer_wdata_r;
  assign port_data_oe   = data_oe_r;
  assign port_rd_strobe = rd_strobe_r;
  assign port_wr_strobe = wr_strobe_r;
  assign ext_out_data   = ext_out_r;

endmodule

// ===== ppa_pkg.sv
// constants shared by the parallel port register block
// assumes a 32-bit apb bus with byte addresses, one word per register
package ppa_pkg;

  // ***************************************************
  // register offsets
  // ***************************************************
  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  OFF_DEST_ADDR  = 8'h00;
  localparam logic [7:0]  OFF_PIN_EN     = 8'h04;
  localparam logic [7:0]  OFF_BUF_STAT   = 8'h08;
  localparam logic [7:0]  OFF_IRQ_STAT   = 8'h0c;
  localparam logic [7:0]  OFF_IRQ_MASK   = 8'h10;
  localparam logic [7:0]  OFF_XFER_CTRL  = 8'h14;
  localparam logic [7:0]  OFF_XFER_DATA  = 8'h18;
  localparam logic [7:0]  OFF_IN_BUF0    = 8'h20;
  localparam logic [7:0]  OFF_OUT_BUF0   = 8'h30;

  // ***************************************************
  // field positions
  // ***************************************************
  localparam int          CS_TWO_BIT     = 15;
  localparam int          CS_ONE_BIT     = 14;
  localparam int          ADDR_MSB       = 13;
  localparam int          ALL_FULL_BIT   = 15;
  localparam int          IN_OVF_BIT     = 14;
  localparam int          IB_FULL_LSB    = 8;
  localparam int          ALL_EMPTY_BIT  = 7;
  localparam int          OUT_UNF_BIT    = 6;
  localparam int          OB_EMPTY_LSB   = 0;
  localparam int          CTRL_WR_BIT    = 0;
  localparam int          CTRL_RD_BIT    = 1;
  localparam int          CTRL_BUSY_BIT  = 2;
  localparam int          IRQ_DONE_BIT   = 0;
  localparam int          IRQ_OVF_BIT    = 1;
  localparam int          IRQ_UNF_BIT    = 2;
  localparam int          IRQ_FULL_BIT   = 3;
  localparam int          IRQ_EMPTY_BIT  = 4;
  localparam int          IRQ_W          = 5;

  // ***************************************************
  // reset values and timing
  // ***************************************************
  localparam logic [15:0] DEST_ADDR_RST  = 16'h0000;
  localparam logic [15:0] PIN_EN_RST     = 16'h0000;
  localparam logic [4:0]  IRQ_RST        = 5'h00;
  localparam logic [7:0]  BYTE_RST       = 8'h00;
  localparam int          GAP_CYCLES     = 1;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_STROBE,
    ST_GAP
  } ppa_xfer_e;

endpackage

// ===== ppa_buf_bank.sv
// bank of byte buffers with one occupancy flag each
// assumes fill and drain strobes are one-cycle pulses in the pclk domain
`timescale 1ns/1ns
module ppa_buf_bank #(
  parameter int NUM = 4,
  parameter int IDX = 2
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [NUM-1:0]   fill,
  input  wire logic [7:0]       fill_data,
  input  wire logic [NUM-1:0]   drain,
  input  wire logic [IDX-1:0]   rd_idx,
  output logic      [7:0]       rd_data,
  output logic      [NUM-1:0]   full_r,
  output logic                  over_evt,
  output logic                  under_evt
);

  logic [7:0] mem_r [NUM];

  // fill on a held byte overwrites it and flags overflow
  assign over_evt  = |(fill & full_r);
  assign under_evt = |(drain & ~full_r);
  assign rd_data   = mem_r[rd_idx];

  genvar g;
  generate
    for (g = 0; g < NUM; g++) begin : g_slot
      // fill beats drain in the same cycle, so fresh data is never lost
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          full_r[g] <= 1'b0;
          mem_r[g]  <= ppa_pkg::BYTE_RST;
        end else if (fill[g]) begin
          full_r[g] <= 1'b1;
          mem_r[g]  <= fill_data;
        end else if (drain[g]) begin
          full_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// ===== ppa_pad_mux.sv
// per-pad choice between port function and general-purpose i/o
// assumes the gpio block supplies its own out and enable levels
`timescale 1ns/1ns
module ppa_pad_mux #(
  parameter int PADS = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [PADS-1:0]  func_en,
  input  wire logic [PADS-1:0]  func_out,
  input  wire logic [PADS-1:0]  gpio_out,
  input  wire logic [PADS-1:0]  gpio_oe,
  output logic      [PADS-1:0]  pad_out_r,
  output logic      [PADS-1:0]  pad_oe_r
);

  genvar g;
  generate
    for (g = 0; g < PADS; g++) begin : g_pad
      wire logic sel_out = func_en[g] ? func_out[g] : gpio_out[g];
      wire logic sel_oe  = func_en[g] ? 1'b1 : gpio_oe[g];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pad_out_r[g] <= 1'b0;
          pad_oe_r[g]  <= 1'b0;
        end else begin
          pad_out_r[g] <= sel_out;
          pad_oe_r[g]  <= sel_oe;
        end
      end
    end
  endgenerate

endmodule

// ===== ppa_periph_model.sv
// behavioural external peripheral on the parallel port's far side
// assumes one-cycle strobes and fill or drain pulses on pclk
`timescale 1ns/1ns
module ppa_periph #(
  parameter int         NBUF    = 4,
  parameter logic [7:0] RD_BYTE = 8'hc3
) (
  input  wire logic            pclk,
  input  wire logic            port_rd_strobe,
  input  wire logic            port_wr_strobe,
  input  wire logic [7:0]      port_data_out,
  input  wire logic            port_data_oe,
  output logic      [7:0]      port_data_in,
  output logic      [NBUF-1:0] ext_in_fill,
  output logic      [7:0]      ext_in_data,
  output logic      [NBUF-1:0] ext_out_drain
);
  logic [7:0] last_wr = 8'h00;
  logic [7:0] idle_q  = 8'h00;
  logic       prev    = 1'b0;
  int         strobes = 0;
  int         adjacent = 0;
  wire        any_stb = port_rd_strobe | port_wr_strobe;
  // released bus toggles so a late sample never sees a held byte
  assign port_data_in = port_rd_strobe ? RD_BYTE : idle_q;
  initial begin
    ext_in_fill = '0;
    ext_in_data = 8'h00;
    ext_out_drain = '0;
  end
  always @(posedge pclk) begin
    idle_q <= ~idle_q;
    prev <= any_stb;
    if (any_stb) strobes <= strobes + 1;
    if (prev && any_stb) adjacent <= adjacent + 1;
    if (port_wr_strobe && port_data_oe) last_wr <= port_data_out;
  end
  task automatic fill(input int i, input logic [7:0] d);
    @(posedge pclk);
    ext_in_fill[i] <= 1'b1;
    ext_in_data <= d;
    @(posedge pclk);
    ext_in_fill <= '0;
    ext_in_data <= ~d;
  endtask
  task automatic drain(input int i);
    @(posedge pclk);
    ext_out_drain[i] <= 1'b1;
    @(posedge pclk);
    ext_out_drain <= '0;
  endtask
endmodule

// ===== ppa_port_properties.sv
// concurrent checks on the parallel port register block
// assumes it sees only ppa_port ports; shadows registers from apb traffic
`timescale 1ns/1ns
module ppa_port_properties #(
  parameter int NBUF = 4
) (
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [7:0]      paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic [15:0]     gpio_out,
  input wire logic [15:0]     gpio_oe,
  input wire logic [15:0]     pad_out,
  input wire logic [15:0]     pad_oe,
  input wire logic            port_rd_strobe,
  input wire logic            port_wr_strobe,
  input wire logic [NBUF-1:0] ext_in_fill,
  input wire logic [NBUF-1:0] ext_out_drain
);
  // ****************
  // shadow state
  // ****************
  logic [15:0]     dest_r, en_r;
  logic [NBUF-1:0] full_r, empty_r;
  logic            unf_r;
  logic [1:0]      live_r;
  wire             wr_done = psel && penable && pready && pwrite && !pslverr;
  wire             rd_done = psel && penable && pready && !pwrite;
  wire             stat_wr = wr_done && paddr == ppa_pkg::OFF_BUF_STAT;
  wire [15:0]      pexp = (en_r & dest_r) | (~en_r & gpio_out);
  wire [15:0]      oexp = en_r | gpio_oe;
  wire [NBUF-1:0]  in_rd, out_wr;
  for (genvar i = 0; i < NBUF; i++) begin : g_sel
    assign in_rd[i] = rd_done && paddr == ppa_pkg::OFF_IN_BUF0 + 8'(4 * i);
    assign out_wr[i] = wr_done && paddr == ppa_pkg::OFF_OUT_BUF0 + 8'(4 * i);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dest_r <= '0;
      en_r <= '0;
      full_r <= '0;
      empty_r <= '1;
      unf_r <= 1'b0;
      live_r <= 2'd0;
    end else begin
      if (wr_done && paddr == ppa_pkg::OFF_DEST_ADDR) dest_r <= pwdata[15:0];
      if (wr_done && paddr == ppa_pkg::OFF_PIN_EN) en_r <= pwdata[15:0];
      full_r <= (full_r & ~in_rd) | ext_in_fill;
      empty_r <= (empty_r | ext_out_drain) & ~out_wr;
      if (|(ext_out_drain & empty_r)) unf_r <= 1'b1;
      else if (stat_wr && !pwdata[6]) unf_r <= 1'b0;
      if (live_r != 2'd2) live_r <= live_r + 2'd1;
    end
  end
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence stat_rd;
    rd_done && paddr == ppa_pkg::OFF_BUF_STAT;
  endsequence
  sequence strobe;
    port_rd_strobe || port_wr_strobe;
  endsequence
  strobe_gap_a: assert property (
    strobe |=> !(port_rd_strobe || port_wr_strobe)) else $error("strobes on adjacent cycles");
  cs_two_a: assert property (
    live_r[1] |-> pad_out[15] == $past(pexp[15])) else $error("chip select two pad wrong");
  cs_one_a: assert property (
    live_r[1] |-> pad_out[14] == $past(pexp[14])) else $error("chip select one pad wrong");
  addr_pads_a: assert property (
    live_r[1] |-> pad_out[13:0] == $past(pexp[13:0])) else $error("address pads wrong");
  pad_oe_a: assert property (
    live_r[1] |-> pad_oe == $past(oexp)) else $error("pad enables wrong");
  stat_resv_a: assert property (
    stat_rd |-> prdata[31:16] == 0 && prdata[13:12] == 0 && prdata[5:4] == 0) else $error("reserved status bits set");
  stat_full_a: assert property (
    stat_rd |-> prdata[8 +: NBUF] == $past(full_r)) else $error("input full flags wrong");
  stat_empty_a: assert property (
    stat_rd |-> prdata[NBUF-1:0] == $past(empty_r) && prdata[7] == &$past(empty_r)) else $error("empty flags wrong");
  stat_unf_a: assert property (
    stat_rd |-> prdata[6] == $past(unf_r)) else $error("underflow flag wrong");
endmodule
bind ppa_port ppa_port_properties #(.NBUF(NBUF)) u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pad_out(pad_out), .pad_oe(pad_oe),
  .port_rd_strobe(port_rd_strobe), .port_wr_strobe(port_wr_strobe), .ext_in_fill(ext_in_fill),
  .ext_out_drain(ext_out_drain));

// ===== parallel_port_addr_pin_status_bench.sv
// self-checking bench for the parallel port register block
// assumes the bound checker and the peripheral model on the far side
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module parallel_port_addr_pin_status_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, re;
  logic [7:0]  paddr, port_data_in, port_data_out, ext_in_data, ext_out_data;
  logic [31:0] pwdata, prdata, rq;
  logic [15:0] gpio_out, gpio_oe, pad_out, pad_oe;
  logic        port_data_oe, port_rd_strobe, port_wr_strobe;
  logic [3:0]  ext_in_fill, ext_out_drain;
  int          err_count = 0;
  int          checks_done = 0;
  ppa_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pad_out(pad_out), .pad_oe(pad_oe),
    .port_data_in(port_data_in), .port_data_out(port_data_out), .port_data_oe(port_data_oe),
    .port_rd_strobe(port_rd_strobe), .port_wr_strobe(port_wr_strobe), .ext_in_fill(ext_in_fill),
    .ext_in_data(ext_in_data), .ext_out_drain(ext_out_drain), .ext_out_data(ext_out_data));
  ppa_periph per (.pclk(pclk), .port_rd_strobe(port_rd_strobe), .port_wr_strobe(port_wr_strobe),
    .port_data_out(port_data_out), .port_data_oe(port_data_oe), .port_data_in(port_data_in),
    .ext_in_fill(ext_in_fill), .ext_in_data(ext_in_data), .ext_out_drain(ext_out_drain));
  // ****************
  // bus tasks
  // ****************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_is(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rq, e)
  endtask
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_regs();
    rd_is(ppa_pkg::OFF_DEST_ADDR, 32'h0);
    rd_is(ppa_pkg::OFF_PIN_EN, 32'h0);
    rd_is(ppa_pkg::OFF_BUF_STAT, 32'h008f);
    wr(ppa_pkg::OFF_DEST_ADDR, 32'hffffffff);
    rd_is(ppa_pkg::OFF_DEST_ADDR, 32'h0000ffff);
    rd_is(8'hfc, 32'h0);
    `CHK(re, 1'b1)
    $display("t_regs done");
  endtask
  task automatic t_pads();
    logic [15:0] en_t [5] = '{16'h0000, 16'hc000, 16'h3ffc, 16'h0003, 16'hffff};
    logic [15:0] ds;
    foreach (en_t[i]) begin
      ds = {i[0], ~i[0], 14'h2a5c + 14'(i)};
      wr(ppa_pkg::OFF_DEST_ADDR, {16'h0, ds});
      wr(ppa_pkg::OFF_PIN_EN, {16'h0, en_t[i]});
      gpio_out <= {gpio_out[14:0], gpio_out[15]};
      settle();
      `CHK(pad_out, (en_t[i] & ds) | (~en_t[i] & gpio_out))
      `CHK(pad_oe, en_t[i] | gpio_oe)
    end
    $display("t_pads done");
  endtask
  task automatic t_buf();
    per.fill(0, 8'h3c);
    per.fill(3, 8'h96);
    rd_is(ppa_pkg::OFF_BUF_STAT, 32'h098f);
    rd_is(ppa_pkg::OFF_IN_BUF0, 32'h3c);
    rd_is(ppa_pkg::OFF_BUF_STAT, 32'h088f);
    per.fill(3, 8'h69);
    wr(ppa_pkg::OFF_OUT_BUF0 + 8'h04, 32'h77);
    rd_is(ppa_pkg::OFF_BUF_STAT, 32'h480d);
    per.drain(1);
    #1;
    `CHK(ext_out_data, 8'h77)
    per.drain(2);
    rd_is(ppa_pkg::OFF_BUF_STAT, 32'h48cf);
    wr(ppa_pkg::OFF_BUF_STAT, 32'hffffffff);
    rd_is(ppa_pkg::OFF_BUF_STAT, 32'h48cf);
    wr(ppa_pkg::OFF_BUF_STAT, 32'h0);
    rd_is(ppa_pkg::OFF_BUF_STAT, 32'h088f);
    apb(1'b0, ppa_pkg::OFF_IN_BUF0 + 8'h0c, 32'h0);
    rd_is(ppa_pkg::OFF_BUF_STAT, 32'h008f);
    $display("t_buf done");
  endtask
  task automatic t_irq();
    apb(1'b0, ppa_pkg::OFF_IRQ_STAT, 32'h0);
    `CHK(rq[2:1], 2'b11)
    wr(ppa_pkg::OFF_IRQ_MASK, 32'h4);
    settle();
    `CHK(irq, 1'b1)
    wr(ppa_pkg::OFF_IRQ_MASK, 32'h0);
    settle();
    `CHK(irq, 1'b0)
    wr(ppa_pkg::OFF_IRQ_MASK, 32'h1f);
    wr(ppa_pkg::OFF_IRQ_STAT, 32'h1f);
    settle();
    `CHK(irq, 1'b0)
    rd_is(ppa_pkg::OFF_IRQ_STAT, 32'h0);
    $display("t_irq done");
  endtask
  task automatic t_xfer();
    wr(ppa_pkg::OFF_XFER_DATA, 32'h5a);
    wr(ppa_pkg::OFF_XFER_CTRL, 32'h3);
    wr(ppa_pkg::OFF_XFER_CTRL, 32'h1);
    rd_is(ppa_pkg::OFF_XFER_CTRL, 32'h4);
    repeat (10) @(posedge pclk);
    rd_is(ppa_pkg::OFF_XFER_CTRL, 32'h0);
    `CHK(per.adjacent == 0, 1'b1)
    `CHK(per.strobes inside {2, 3}, 1'b1)
    `CHK(per.last_wr, 8'h5a)
    rd_is(ppa_pkg::OFF_XFER_DATA, 32'hc35a);
    apb(1'b0, ppa_pkg::OFF_IRQ_STAT, 32'h0);
    `CHK(rq[0], 1'b1)
    $display("t_xfer done");
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #100000;
    err_count++;
    results();
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    gpio_out = 16'ha5c3;
    gpio_oe = 16'h0ff0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_pads();
    t_buf();
    t_irq();
    t_xfer();
    results();
  end
endmodule
